/* shared/fcrs_pkg.sv */
package fcrs_pkg;
  localparam int unsigned FCRS_AW = 16;
  localparam int unsigned FCRS_DW = 8;
  localparam int unsigned FCRS_NLINES = 256;
  localparam int unsigned FCRS_CODEW = 8;

  // opcode assignments of this sequencer
  localparam logic [7:0] FCRS_OP_CALL = 8'hCD;
  localparam logic [7:0] FCRS_OP_RET = 8'hC9;
  localparam logic [7:0] FCRS_OP_JMP = 8'hC3;
  // two-byte class: top bits 00, low bits 110
  localparam logic [1:0] FCRS_IMM_TOP = 2'h0;
  localparam logic [2:0] FCRS_IMM_LOW = 3'h6;

  localparam logic [15:0] FCRS_PC_RESET = 16'h0000;
  localparam logic [15:0] FCRS_SP_RESET = 16'h0000;
  localparam logic [15:0] FCRS_ADDR_STEP = 16'h0001;
  localparam logic [15:0] FCRS_RA_BYTES = 16'h0002;

  localparam logic [1:0] FCRS_LEN_1 = 2'h1;
  localparam logic [1:0] FCRS_LEN_2 = 2'h2;
  localparam logic [1:0] FCRS_LEN_3 = 2'h3;
  localparam logic [1:0] FCRS_CNT_ZERO = 2'h0;
  localparam logic [1:0] FCRS_CNT_STEP = 2'h1;

  typedef enum logic [2:0] {
    FCRS_PH_FETCH_REQ = 3'b000,
    FCRS_PH_FETCH_WAIT = 3'b001,
    FCRS_PH_EXEC = 3'b010,
    FCRS_PH_PUSH_HI = 3'b011,
    FCRS_PH_PUSH_LO = 3'b100,
    FCRS_PH_POP_LO = 3'b101,
    FCRS_PH_POP_HI = 3'b110
  } fcrs_phase_t;

  typedef struct packed {
    fcrs_phase_t phase;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0] ir;
    logic [15:0] opnd;
    logic [7:0] pop_lo;
    logic [1:0] cnt;
    logic [1:0] len;
    logic [15:0] mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic exec;
    logic [FCRS_NLINES-1:0] action;
  } fcrs_state_t;

  function automatic logic [1:0] fcrs_instr_len(input logic [7:0] op);
    logic [1:0] len;
    len = FCRS_LEN_1;
    if (op == FCRS_OP_CALL || op == FCRS_OP_JMP) begin
      len = FCRS_LEN_3;
    end else if (op[7:6] == FCRS_IMM_TOP && op[2:0] == FCRS_IMM_LOW) begin
      len = FCRS_LEN_2;
    end
    return len;
  endfunction : fcrs_instr_len
endpackage : fcrs_pkg

/* shared/fcrs_dec_if.sv */
interface fcrs_dec_if;
  logic [fcrs_pkg::FCRS_CODEW-1:0] code;
  logic [fcrs_pkg::FCRS_NLINES-1:0] lines;
  modport dec (input code, output lines);
  modport ctl (output code, input lines);
endinterface : fcrs_dec_if

/* rtl/fcrs_decoder.sv */
module fcrs_decoder (
  fcrs_dec_if.dec bus
);
  import fcrs_pkg::*;

  // one line per opcode value, exactly one high
  genvar g;
  generate
    for (g = 0; g < FCRS_NLINES; g++) begin : g_line
      assign bus.lines[g] = (bus.code == FCRS_CODEW'(g));
    end
  endgenerate
endmodule : fcrs_decoder

/* rtl/fcrs_sequencer.sv */
// Summary of operation
// - A call advances the program counter past itself and pushes that return address before any new fetch.
// - After the push, the program counter takes the call's target so the next fetch is the subroutine.
// - A return reloads the program counter from the top of the stack.
// - A return has no operand bytes; its destination comes only from the stack.
// - Calls nest as deep as the stack memory allows, one return address per level.
// - The stack lives in memory and the pointer always holds the address of the latest stored entry.
// - Memory is byte addressed, eight bits per location, wider values take whole bytes.
// - Every operation has a unique eight-bit code, up to 256 of them.
// - A fetch first drives the program counter as address, then captures the returned byte.
// - The program counter advances by one for every instruction byte fetched.
// - The opcode is decoded to one of 256 lines, gated by the execute pulse.
// - Instructions with operands take two or three fetches from increasing adjacent addresses.
// - Only the first byte goes to the instruction register; operand bytes go to holding storage.
// - Execution starts only after all bytes of the instruction are fetched.
// - While ready is low the current access is held in wait states and resumes when it rises.
module fcrs_sequencer #(
  parameter logic [15:0] PC_RESET = fcrs_pkg::FCRS_PC_RESET,
  parameter logic [15:0] SP_RESET = fcrs_pkg::FCRS_SP_RESET
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_ready,
  input wire logic [fcrs_pkg::FCRS_DW-1:0] i_mem_rdata,
  output logic [fcrs_pkg::FCRS_AW-1:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [fcrs_pkg::FCRS_DW-1:0] o_mem_wdata,
  output logic [fcrs_pkg::FCRS_CODEW-1:0] o_ir,
  output logic [fcrs_pkg::FCRS_AW-1:0] o_pc,
  output logic [fcrs_pkg::FCRS_AW-1:0] o_sp,
  output logic [fcrs_pkg::FCRS_AW-1:0] o_operand,
  output logic o_exec,
  output logic [fcrs_pkg::FCRS_NLINES-1:0] o_action
);
  import fcrs_pkg::*;

  localparam fcrs_state_t ST_RESET = '{
    phase: FCRS_PH_FETCH_REQ,
    pc: PC_RESET,
    sp: SP_RESET,
    ir: '0,
    opnd: '0,
    pop_lo: '0,
    cnt: FCRS_CNT_ZERO,
    len: FCRS_LEN_1,
    mem_addr: '0,
    mem_rd: 1'b0,
    mem_wr: 1'b0,
    mem_wdata: '0,
    exec: 1'b0,
    action: '0
  };

  fcrs_state_t st;
  fcrs_state_t next_st;

  fcrs_dec_if u_dec_if ();

  assign u_dec_if.code = st.ir;

  fcrs_decoder u_decoder (
    .bus(u_dec_if.dec)
  );

  always_comb begin
    next_st = st;
    next_st.exec = 1'b0;
    next_st.action = '0;
    unique case (st.phase)
      FCRS_PH_FETCH_REQ: begin
        next_st.mem_addr = st.pc;
        next_st.mem_rd = 1'b1;
        next_st.phase = FCRS_PH_FETCH_WAIT;
      end
      FCRS_PH_FETCH_WAIT: begin
        // slow memory stretches this state by holding ready low
        if (i_ready) begin
          next_st.mem_rd = 1'b0;
          next_st.pc = st.pc + FCRS_ADDR_STEP;
          if (st.cnt == FCRS_CNT_ZERO) begin
            next_st.ir = i_mem_rdata;
            next_st.len = fcrs_instr_len(i_mem_rdata);
          end else if (st.cnt == FCRS_CNT_STEP) begin
            next_st.opnd[7:0] = i_mem_rdata;
          end else begin
            next_st.opnd[15:8] = i_mem_rdata;
          end
          next_st.cnt = st.cnt + FCRS_CNT_STEP;
          // execute only once the whole instruction is in
          if (next_st.cnt == next_st.len) begin
            next_st.phase = FCRS_PH_EXEC;
          end else begin
            next_st.phase = FCRS_PH_FETCH_REQ;
          end
        end
      end
      FCRS_PH_EXEC: begin
        next_st.exec = 1'b1;
        next_st.action = u_dec_if.lines;
        next_st.cnt = FCRS_CNT_ZERO;
        next_st.phase = FCRS_PH_FETCH_REQ;
        if (st.ir == FCRS_OP_CALL) begin
          // pc already points past the call: that is the return address
          next_st.mem_addr = st.sp - FCRS_ADDR_STEP;
          next_st.mem_wdata = st.pc[15:8];
          next_st.mem_wr = 1'b1;
          next_st.phase = FCRS_PH_PUSH_HI;
        end else if (st.ir == FCRS_OP_RET) begin
          next_st.mem_addr = st.sp;
          next_st.mem_rd = 1'b1;
          next_st.phase = FCRS_PH_POP_LO;
        end else if (st.ir == FCRS_OP_JMP) begin
          next_st.pc = st.opnd;
        end
      end
      FCRS_PH_PUSH_HI: begin
        if (i_ready) begin
          next_st.mem_addr = st.sp - FCRS_RA_BYTES;
          next_st.mem_wdata = st.pc[7:0];
          next_st.phase = FCRS_PH_PUSH_LO;
        end
      end
      FCRS_PH_PUSH_LO: begin
        if (i_ready) begin
          next_st.mem_wr = 1'b0;
          // stack grows down, so nesting is bounded only by memory
          next_st.sp = st.sp - FCRS_RA_BYTES;
          next_st.pc = st.opnd;
          next_st.phase = FCRS_PH_FETCH_REQ;
        end
      end
      FCRS_PH_POP_LO: begin
        if (i_ready) begin
          next_st.pop_lo = i_mem_rdata;
          next_st.mem_addr = st.sp + FCRS_ADDR_STEP;
          next_st.phase = FCRS_PH_POP_HI;
        end
      end
      FCRS_PH_POP_HI: begin
        if (i_ready) begin
          next_st.mem_rd = 1'b0;
          next_st.pc = {i_mem_rdata, st.pop_lo};
          next_st.sp = st.sp + FCRS_RA_BYTES;
          next_st.phase = FCRS_PH_FETCH_REQ;
        end
      end
      default: begin
        // unused code 3'b111: drop any strobe and refetch
        next_st.mem_rd = 1'b0;
        next_st.mem_wr = 1'b0;
        next_st.phase = FCRS_PH_FETCH_REQ;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      st <= ST_RESET;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_mem_addr = st.mem_addr;
  assign o_mem_rd = st.mem_rd;
  assign o_mem_wr = st.mem_wr;
  assign o_mem_wdata = st.mem_wdata;
  assign o_ir = st.ir;
  assign o_pc = st.pc;
  assign o_sp = st.sp;
  assign o_operand = st.opnd;
  assign o_exec = st.exec;
  assign o_action = st.action;

  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  sequence s_step(fcrs_phase_t ph);
    i_ce && st.phase == ph;
  endsequence

  sequence s_done(fcrs_phase_t ph);
    i_ce && st.phase == ph && i_ready;
  endsequence

  sequence s_call_exec;
    s_step(FCRS_PH_EXEC) ##0 st.ir == FCRS_OP_CALL;
  endsequence

  sequence s_ret_exec;
    s_step(FCRS_PH_EXEC) ##0 st.ir == FCRS_OP_RET;
  endsequence

  a_fetch_addr_out: assert property (
    s_step(FCRS_PH_FETCH_REQ) |=> o_mem_rd && !o_mem_wr && o_mem_addr == $past(st.pc))
    else $error("fetch did not drive program counter as address");

  a_pc_byte_step: assert property (
    s_done(FCRS_PH_FETCH_WAIT) |=> st.pc == $past(st.pc) + FCRS_ADDR_STEP)
    else $error("program counter did not advance by one per byte");

  a_wait_hold: assert property (
    s_step(FCRS_PH_FETCH_WAIT) ##0 !i_ready |=> st.phase == FCRS_PH_FETCH_WAIT && o_mem_rd && $stable(o_mem_addr))
    else $error("access not held while ready low");

  a_ir_first_byte: assert property (
    s_done(FCRS_PH_FETCH_WAIT) ##0 st.cnt == FCRS_CNT_ZERO |=> st.ir == $past(i_mem_rdata))
    else $error("first byte not in instruction register");

  a_operand_hold: assert property (
    s_done(FCRS_PH_FETCH_WAIT) ##0 st.cnt == FCRS_CNT_STEP
      |=> st.opnd[7:0] == $past(i_mem_rdata) && $stable(st.ir))
    else $error("operand byte misplaced");

  a_exec_complete: assert property (
    // a frozen clock enable may keep the sequencer in execute for extra cycles
    st.phase == FCRS_PH_EXEC |-> st.cnt == st.len && ($past(st.phase) == FCRS_PH_FETCH_WAIT
      || ($past(st.phase) == FCRS_PH_EXEC && !$past(i_ce))))
    else $error("execute began before all bytes were fetched");

  a_call_push_hi: assert property (
    s_call_exec |=> o_mem_wr && o_mem_addr == $past(st.sp) - FCRS_ADDR_STEP && o_mem_wdata == st.pc[15:8]
      && st.phase == FCRS_PH_PUSH_HI)
    else $error("call did not push return address high byte");

  a_call_target: assert property (
    s_done(FCRS_PH_PUSH_LO) |=> st.pc == $past(st.opnd) && st.sp == $past(st.sp) - FCRS_RA_BYTES
      && !o_mem_wr && st.phase == FCRS_PH_FETCH_REQ)
    else $error("call target or stack pointer wrong");

  a_ret_from_stack: assert property (
    s_ret_exec |=> o_mem_rd && o_mem_addr == $past(st.sp) && st.phase == FCRS_PH_POP_LO)
    else $error("return did not read the stack top");

  a_ret_reload: assert property (
    s_done(FCRS_PH_POP_HI) |=> st.pc == {$past(i_mem_rdata), $past(st.pop_lo)}
      && st.sp == $past(st.sp) + FCRS_RA_BYTES)
    else $error("return address not reloaded from stack");

  a_action_onehot: assert property (
    o_exec |-> o_action == (FCRS_NLINES'(1) << o_ir))
    else $error("action line does not match opcode");

  a_action_gated: assert property (
    !o_exec |-> o_action == '0)
    else $error("action line active outside execute pulse");
endmodule : fcrs_sequencer

/* testbench/fcrs_mem_model.sv */
module fcrs_mem_model (
  input wire logic i_clk_sys,
  input wire logic i_ce,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [1:0] i_max_wait,
  output logic o_ready,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  logic [1:0] wait_cnt = 2'h0;
  // wait count is drawn at the end of each access, so ready is already low when the next address arrives if the drawn count is nonzero
  assign o_ready = (wait_cnt == 2'h0);
  // released bus shows the inverse of the last byte, not a stale copy
  assign o_rdata = i_rd ? mem[i_addr] : ~last;
  always @(posedge i_clk_sys) begin
    if (i_rd || i_wr) begin
      if (!o_ready) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (i_ce) begin
        wait_cnt <= 2'($urandom_range(i_max_wait));
        if (i_wr) begin
          mem[i_addr] <= i_wdata;
        end
        last <= o_rdata;
      end
    end
  end
endmodule : fcrs_mem_model

/* testbench/fcrs_sequencer_bench.sv */
module fcrs_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fcrs_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [1:0] max_wait = 2'h0;
  logic ready, rd, wr, exec;
  logic [7:0] rdata, wdata, ir, imm, op1;
  logic [15:0] addr, pc, sp, opnd;
  logic [255:0] action;
  int mismatches = 0;
  int tests_run = 0;
  logic [15:0] rd_q[$];
  logic [23:0] wr_q[$];
  logic [23:0] ex_q[$];
  logic [15:0] sp_q[$];
  localparam logic [15:0] rd_exp [18] = '{16'h0000, 16'h0001, 16'h0002, 16'h0100, 16'h0101, 16'h0102,
    16'h0200, 16'h0201, 16'h0202, 16'h0203, 16'hFFFC, 16'hFFFD, 16'h0103, 16'hFFFE, 16'hFFFF,
    16'h0003, 16'h0004, 16'h0005};
  localparam logic [23:0] wr_exp [4] = '{24'hFFFF00, 24'hFFFE03, 24'hFFFD01, 24'hFFFC03};
  always #5 clk = ~clk;
  fcrs_sequencer fcrs_sequencer_inst (.i_clk_sys(clk), .i_rstn(rstn), .i_ce(ce), .i_ready(ready),
    .i_mem_rdata(rdata), .o_mem_addr(addr), .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_wdata(wdata),
    .o_ir(ir), .o_pc(pc), .o_sp(sp), .o_operand(opnd), .o_exec(exec), .o_action(action));
  fcrs_mem_model fcrs_mem_model_inst (.i_clk_sys(clk), .i_ce(ce), .i_addr(addr), .i_rd(rd), .i_wr(wr),
    .i_wdata(wdata), .i_max_wait(max_wait), .o_ready(ready), .o_rdata(rdata));
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  function automatic logic is_one(input logic [7:0] op);
    return op != 8'hCD && op != 8'hC9 && op != 8'hC3 && !(op[7:6] == 2'h0 && op[2:0] == 3'h6);
  endfunction : is_one
  // expected opcode of the n-th executed instruction of the test program
  function automatic logic [7:0] exp_op(input int n);
    logic [7:0] t [7];
    t = '{8'hCD, 8'hCD, 8'h06, op1, 8'hC9, 8'hC9, 8'hC3};
    return t[n];
  endfunction : exp_op
  task automatic load();
    logic [23:0] p [18];
    p = '{24'h0000CD, 24'h000100, 24'h000201, 24'h0003C3, 24'h000403, 24'h000500, 24'h0100CD, 24'h010100,
      24'h010202, 24'h0103C9, 24'h020006, {16'h0201, imm}, {16'h0202, op1}, 24'h0203C9, 24'hFFFCA5,
      24'hFFFDA5, 24'hFFFEA5, 24'hFFFFA5};
    foreach (p[i]) fcrs_mem_model_inst.mem[p[i][23:8]] = p[i][7:0];
  endtask : load
  always @(posedge clk) begin
    if (rstn && ce && ready && rd) rd_q.push_back(addr);
    if (rstn && ce && ready && wr) wr_q.push_back({addr, wdata});
    if (rstn && ce && exec) begin
      ex_q.push_back({ir, opnd});
      sp_q.push_back(sp);
      chk("action", 32'(action == (256'h1 << ir)), 32'h1);
    end
  end
  initial begin
    #300us;
    mismatches++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h2E60));
    for (int pass = 0; pass < 2; pass++) begin
      @(negedge clk);
      rstn = 1'b0;
      ce = 1'b1;
      imm = 8'($urandom);
      do op1 = 8'($urandom); while (!is_one(op1));
      load();
      max_wait = 2'(pass * 3);
      repeat (10) @(negedge clk);
      chk("pc_reset", 32'(pc), 32'h0);
      chk("rd_reset", 32'(rd), 32'h0);
      rd_q.delete();
      wr_q.delete();
      ex_q.delete();
      sp_q.delete();
      rstn = 1'b1;
      for (int n = 0; n < 3000 && ex_q.size() < 7; n++) begin
        @(negedge clk);
        ce = ($urandom_range(7) != 0);
      end
      ce = 1'b1;
      chk("exec_count", 32'(ex_q.size()), 32'h7);
      chk("read_count", 32'(rd_q.size() >= 18), 32'h1);
      for (int i = 0; i < 18; i++) chk("read_addr", 32'(rd_q[i]), 32'(rd_exp[i]));
      chk("write_count", 32'(wr_q.size()), 32'h4);
      for (int i = 0; i < 4; i++) chk("push", 32'(wr_q[i]), 32'(wr_exp[i]));
      for (int i = 0; i < 7; i++) chk("opcode", 32'(ex_q[i][23:16]), 32'(exp_op(i)));
      chk("call_target", 32'(ex_q[1][15:0]), 32'h0200);
      chk("imm_byte", 32'(ex_q[2][7:0]), 32'(imm));
      chk("jump_target", 32'(ex_q[6][15:0]), 32'h0003);
      chk("sp_nested", 32'(sp_q[2]), 32'hFFFC);
      chk("sp_unwound", 32'(sp_q[6]), 32'h0000);
    end
    end_sim();
  end
endmodule : fcrs_sequencer_bench
